/* File: common/psov_regs.svh */
// register map and fixed values of the power-state override block.
// assumes inclusion by bare name from the package and the design files.
`ifndef PSOV_REGS_SVH
`define PSOV_REGS_SVH

// --------------------------------------------------------------------
// register map
// --------------------------------------------------------------------
`define PSOV_OVR_ADDR 8'h12
`define PSOV_OVR_RESET 3'h0
`define PSOV_RSVD_READ 5'h00
`define PSOV_READ_IDLE 8'h00

// --------------------------------------------------------------------
// field positions inside the override register
// --------------------------------------------------------------------
`define PSOV_BIT_FORCE_FULL 0
`define PSOV_BIT_FORCE_DEEP 1
`define PSOV_BIT_IGNORE_DEEP 2

// --------------------------------------------------------------------
// power-state encodings
// --------------------------------------------------------------------
`define PSOV_STATE_FULL 3'h0
`define PSOV_STATE_DEEP 3'h7

// --------------------------------------------------------------------
// serial management bus
// --------------------------------------------------------------------
// target address; the value is arbitrary
`define PSOV_DEV_ADDR 7'h2A
`define PSOV_LAST_BIT 3'h7
`define PSOV_BIT_ZERO 3'h0
`define PSOV_PTR_STEP 8'h01
// bit counter step, sized to the 3-bit counter
`define PSOV_CNT_STEP 3'h1

`endif

/* File: common/psov_pkg.sv */
// types shared by the power-state override design files.
// assumes psov_regs.svh is on the include path.
`include "psov_regs.svh"

package psov_pkg;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  // power-state command from the processor voltage interface decoder
  typedef struct packed {
    logic valid;
    logic [2:0] state;
  } psov_cmd_t;

  // operating request handed to the phase engine
  typedef struct packed {
    logic [2:0] op_state;
    logic full_phase;
    logic phase_mgmt_en;
  } psov_vr_t;

  // ------------------------------------------------------------------
  // management bus target states, gray along the write path
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    PSOV_IDLE = 4'h0,
    PSOV_ADDR = 4'h1,
    PSOV_AACK = 4'h3,
    PSOV_PTR = 4'h2,
    PSOV_PACK = 4'h6,
    PSOV_WDAT = 4'h7,
    PSOV_WACK = 4'h5,
    PSOV_RDAT = 4'h4,
    PSOV_RACK = 4'hC
  } psov_bus_st_t;

endpackage

/* File: hdl/psov_mode_resolve.sv */
// combinational resolution of override bits against the commanded state.
// assumes its inputs are stable register outputs of the same clock.
`timescale 1ns/10ps
`include "psov_regs.svh"

module psov_mode_resolve (
  input wire logic [2:0] ovr,
  input wire logic [2:0] req_state,
  output psov_pkg::psov_vr_t vr
);
  import psov_pkg::*;

  // ------------------------------------------------------------------
  // override priority
  // ------------------------------------------------------------------
  // full-power force outranks everything; deep force is cancelled by
  // the ignore bit, which gives plain following again
  always_comb begin
    vr.op_state = req_state;
    vr.full_phase = (req_state == `PSOV_STATE_FULL);
    vr.phase_mgmt_en = 1'b1;
    if (ovr[`PSOV_BIT_FORCE_FULL]) begin
      // full power, commands ignored [RULE7]
      vr.op_state = `PSOV_STATE_FULL;
      vr.full_phase = 1'b1;
      vr.phase_mgmt_en = 1'b0;
    end else if (ovr[`PSOV_BIT_FORCE_DEEP]) begin
      if (!ovr[`PSOV_BIT_IGNORE_DEEP]) begin
        // deep state, phase management off [RULE7]
        vr.op_state = `PSOV_STATE_DEEP;
        vr.full_phase = 1'b0;
        vr.phase_mgmt_en = 1'b0;
      end
    end else if (ovr[`PSOV_BIT_IGNORE_DEEP]) begin
      if (req_state == `PSOV_STATE_DEEP) begin
        // deep command replaced by full phase count [RULE4] [RULE5]
        vr.op_state = `PSOV_STATE_FULL;
        vr.full_phase = 1'b1;
        vr.phase_mgmt_en = 1'b0;
      end
    end
    // with all bits clear the request passes untouched [RULE3]
  end

endmodule

/* File: hdl/psov_ctrl.sv */
// power-state override register with its serial management target.
// assumes scl and sda arrive unsynchronised from pins, and that the
// command input comes from logic on core_clk.
//
// Notes on behaviour
// RULE1 - 8-bit register at 12h, bits 2:0 cleared at reset
// RULE2 - bits 7:3 read back as zero
// RULE3 - ignore bit clear: follow every commanded state; with a force bit set (1h, 2h, 3h) the forced state is used instead
// RULE4 - ignore bit set: deep command keeps full phases; with deep force also set (6h) the deep command passes as deep
// RULE5 - only deep state substituted, others honoured
// RULE6 - report register and acknowledge always follow commands
// RULE7 - full force first; deep force unless ignore set
`timescale 1ns/10ps
`include "psov_regs.svh"

module psov_ctrl (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input psov_pkg::psov_cmd_t cmd,
  output logic cmd_ack,
  output logic [2:0] reported_state,
  output psov_pkg::psov_vr_t vr,
  output logic [2:0] override_bits
);
  import psov_pkg::*;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [2:0] scl_q; // stage 0 is the metastable catcher
  logic [2:0] sda_q; // stage 2 is the edge-detect history

  // only registers; stage 0 is read by stage 1 alone
  always_ff @(posedge core_clk) begin
    if (srst) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else if (ce) begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  // bus events from the settled stages
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic sda_bit;
  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign bus_start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign bus_stop = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  assign sda_bit = sda_q[1];

  // ------------------------------------------------------------------
  // bus target state
  // ------------------------------------------------------------------
  psov_bus_st_t st_q, st_d; // target phase
  logic [7:0] sh_q, sh_d; // shift register, in and out
  logic [2:0] cnt_q, cnt_d; // bit counter inside a byte
  logic done_q, done_d; // byte complete, waiting for scl low
  logic rw_q, rw_d; // transfer direction, high for read
  logic drive_q, drive_d; // pull sda low
  logic [7:0] ptr_q, ptr_d; // register pointer
  logic [2:0] ovr_q, ovr_d; // override bits
  logic [7:0] rdata; // read view at the pointer

  // read view; only the override register is mapped here
  always_comb begin
    if (ptr_q == `PSOV_OVR_ADDR) begin
      rdata = {`PSOV_RSVD_READ, ovr_q}; // [RULE2]
    end else begin
      rdata = `PSOV_READ_IDLE;
    end
  end

  // next-state of the target; start and stop win over any phase so a
  // glitching master always gets a clean restart
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    done_d = done_q;
    rw_d = rw_q;
    drive_d = drive_q;
    ptr_d = ptr_q;
    ovr_d = ovr_q;
    if (bus_start) begin
      // fresh or repeated start
      st_d = PSOV_ADDR;
      cnt_d = `PSOV_BIT_ZERO;
      done_d = 1'b0;
      drive_d = 1'b0;
    end else if (bus_stop) begin
      st_d = PSOV_IDLE;
      done_d = 1'b0;
      drive_d = 1'b0;
    end else begin
      case (st_q)
        PSOV_ADDR, PSOV_PTR, PSOV_WDAT: begin
          if (scl_rise) begin
            // sample while scl is high
            sh_d = {sh_q[6:0], sda_bit};
            cnt_d = cnt_q + `PSOV_CNT_STEP;
            done_d = (cnt_q == `PSOV_LAST_BIT);
          end else if (scl_fall && done_q) begin
            done_d = 1'b0;
            drive_d = 1'b1;
            if (st_q == PSOV_ADDR) begin
              if (sh_q[7:1] == `PSOV_DEV_ADDR) begin
                rw_d = sh_q[0];
                st_d = PSOV_AACK;
              end else begin
                // not ours: stay silent until the next start
                drive_d = 1'b0;
                st_d = PSOV_IDLE;
              end
            end else if (st_q == PSOV_PTR) begin
              ptr_d = sh_q;
              st_d = PSOV_PACK;
            end else begin
              // writes elsewhere are acknowledged and dropped
              if (ptr_q == `PSOV_OVR_ADDR) begin
                ovr_d = sh_q[2:0]; // [RULE1]
              end
              ptr_d = ptr_q + `PSOV_PTR_STEP;
              st_d = PSOV_WACK;
            end
          end
        end
        PSOV_AACK: begin
          if (scl_fall) begin
            cnt_d = `PSOV_BIT_ZERO;
            if (rw_q) begin
              // first data bit goes out right after the ack
              drive_d = ~rdata[7];
              sh_d = {rdata[6:0], 1'b0};
              ptr_d = ptr_q + `PSOV_PTR_STEP;
              st_d = PSOV_RDAT;
            end else begin
              drive_d = 1'b0;
              st_d = PSOV_PTR;
            end
          end
        end
        PSOV_PACK, PSOV_WACK: begin
          if (scl_fall) begin
            drive_d = 1'b0;
            cnt_d = `PSOV_BIT_ZERO;
            st_d = PSOV_WDAT;
          end
        end
        PSOV_RDAT: begin
          if (scl_fall) begin
            if (cnt_q == `PSOV_LAST_BIT) begin
              // release for the master's ack bit
              drive_d = 1'b0;
              st_d = PSOV_RACK;
            end else begin
              drive_d = ~sh_q[7];
              sh_d = {sh_q[6:0], 1'b0};
              cnt_d = cnt_q + `PSOV_CNT_STEP;
            end
          end
        end
        PSOV_RACK: begin
          if (scl_rise) begin
            if (sda_bit) begin
              // not acknowledged: read ends
              st_d = PSOV_IDLE;
            end else begin
              done_d = 1'b1;
            end
          end else if (scl_fall && done_q) begin
            done_d = 1'b0;
            drive_d = ~rdata[7];
            sh_d = {rdata[6:0], 1'b0};
            ptr_d = ptr_q + `PSOV_PTR_STEP;
            cnt_d = `PSOV_BIT_ZERO;
            st_d = PSOV_RDAT;
          end
        end
        PSOV_IDLE: begin
          drive_d = 1'b0;
        end
        default: begin
          st_d = PSOV_IDLE;
          drive_d = 1'b0;
        end
      endcase
    end
  end

  // registers of the target; ce low freezes everything
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= PSOV_IDLE;
      sh_q <= `PSOV_READ_IDLE;
      cnt_q <= `PSOV_BIT_ZERO;
      done_q <= 1'b0;
      rw_q <= 1'b0;
      drive_q <= 1'b0;
      ptr_q <= `PSOV_READ_IDLE;
      ovr_q <= `PSOV_OVR_RESET; // [RULE1]
    end else if (ce) begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      rw_q <= rw_d;
      drive_q <= drive_d;
      ptr_q <= ptr_d;
      ovr_q <= ovr_d;
    end
  end

  // open-drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_q;
  assign override_bits = ovr_q;

  // ------------------------------------------------------------------
  // power-state handling
  // ------------------------------------------------------------------
  logic [2:0] rpt_q, rpt_d; // reported power state
  logic ack_q, ack_d; // command acknowledge pulse
  psov_vr_t vr_q, vr_d; // request to the phase engine
  logic [2:0] req_state; // state the resolver judges

  // a new command is judged at once; otherwise the last report is
  // re-judged so a register write takes effect without a command
  assign req_state = cmd.valid ? cmd.state : rpt_q;

  psov_mode_resolve u_resolve (
    .ovr(ovr_q),
    .req_state(req_state),
    .vr(vr_d)
  );

  // report and acknowledge ignore the override bits entirely
  always_comb begin
    rpt_d = rpt_q;
    ack_d = 1'b0;
    if (cmd.valid) begin
      rpt_d = cmd.state; // [RULE6]
      ack_d = 1'b1; // [RULE6]
    end
  end

  // registers of the power-state path
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rpt_q <= `PSOV_STATE_FULL;
      ack_q <= 1'b0;
      vr_q <= {`PSOV_STATE_FULL, 1'b1, 1'b1};
    end else if (ce) begin
      rpt_q <= rpt_d;
      ack_q <= ack_d;
      vr_q <= vr_d; // [RULE3] [RULE4] [RULE5] [RULE7]
    end
  end

  assign cmd_ack = ack_q;
  assign reported_state = rpt_q;
  assign vr = vr_q;

endmodule

/* File: bench/psov_ctrl_assertions.sv */
// port-level assertions for the power-state override block.
// assumes a bind onto psov_ctrl from the bench top file.
`timescale 1ns/10ps

module psov_ctrl_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input psov_pkg::psov_cmd_t cmd,
  input wire logic cmd_ack,
  input wire logic [2:0] reported_state,
  input psov_pkg::psov_vr_t vr,
  input wire logic [2:0] override_bits
);
  import psov_pkg::*;
  // ------------------------------------------------------------------
  // one clock domain only
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // a command taken on an enabled edge
  sequence s_cmd;
    ce && cmd.valid;
  endsequence
  sequence s_idle;
    ce && !cmd.valid;
  endsequence

  chk_ack_pulse: assert property (s_cmd |=> cmd_ack)
    else $error("command not acknowledged");
  chk_ack_quiet: assert property (s_idle |=> !cmd_ack)
    else $error("ack without command");
  chk_report_track: assert property (
    s_cmd |=> reported_state == $past(cmd.state))
    else $error("reported state wrong");
  chk_force_full: assert property (
    ce && override_bits[0] |=> vr == {3'h0, 1'b1, 1'b0})
    else $error("force full not applied");
  chk_force_deep: assert property (
    ce && override_bits == 3'h2 |=> vr == {3'h7, 1'b0, 1'b0})
    else $error("force deep not applied");
  chk_ignore_deep: assert property (
    s_cmd ##0 (override_bits == 3'h4 && cmd.state == 3'h7)
    |=> vr == {3'h0, 1'b1, 1'b0})
    else $error("deep state not substituted");
  chk_follow_all: assert property (
    s_cmd ##0 (override_bits == 3'h0 || override_bits == 3'h6)
    |=> vr.op_state == $past(cmd.state) && vr.phase_mgmt_en)
    else $error("commanded state not followed");
  chk_other_kept: assert property (
    s_cmd ##0 (override_bits == 3'h4 && cmd.state != 3'h7)
    |=> vr.op_state == $past(cmd.state))
    else $error("other state not honoured");
  chk_reset_clr: assert property (disable iff (1'b0)
    srst && ce |=> override_bits == 3'h0 && reported_state == 3'h0)
    else $error("reset values wrong");
  // enable low: nothing of the command path may move
  chk_freeze_hold: assert property (
    !ce |=> $stable(reported_state) && $stable(vr) && $stable(cmd_ack))
    else $error("state moved while enable low");
endmodule

/* File: bench/psov_cmd_src.sv */
// command source standing in for the processor voltage interface.
// assumes the bench calls send once for every falling edge it drives.
`timescale 1ns/10ps

module psov_cmd_src (
  input wire logic core_clk,
  output psov_pkg::psov_cmd_t cmd
);
  import psov_pkg::*;
  initial cmd = '0;
  // valid is a one-cycle pulse; while idle the state lines show the
  // inverse of the last value so nothing leans on a stale state
  task automatic send(input logic vld, input logic [2:0] st);
    @(negedge core_clk);
    cmd = '{valid: vld, state: vld ? st : ~cmd.state};
  endtask
endmodule

/* File: bench/test_power_state_override_ctrl.sv */
// self-checking bench for the power-state override block.
// assumes package, header and design files are compiled first.
`timescale 1ns/10ps
`include "psov_regs.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
  error_cnt++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end

module test_power_state_override_ctrl;
  import psov_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic sda_out, sda_oe_n, cmd_ack;
  logic [2:0] reported_state, override_bits;
  psov_cmd_t cmd;
  psov_vr_t vr;
  int error_cnt = 0;
  int num_checks = 0;
  // open-drain data wire with pull-up
  wire sda = sda_m & (sda_oe_n | sda_out);

  always #4 core_clk = ~core_clk;
  psov_cmd_src cmd_u (.core_clk(core_clk), .cmd(cmd));
  psov_ctrl dut_u (.core_clk(core_clk), .srst(srst), .ce(ce),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .cmd(cmd), .cmd_ack(cmd_ack), .reported_state(reported_state),
    .vr(vr), .override_bits(override_bits));

  // expected phase-engine request for override bits o and state s
  function automatic psov_vr_t exp_vr(input logic [2:0] o,
                                      input logic [2:0] s);
    if (o[0]) return '{3'h0, 1'b1, 1'b0};
    if (o[1] && !o[2]) return '{3'h7, 1'b0, 1'b0};
    if (o[2] && !o[1] && s == 3'h7) return '{3'h0, 1'b1, 1'b0};
    return '{s, s == 3'h0, 1'b1};
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // ------------------------------------------------------------------
  // bus master: data bits move only while the bus clock is low; start and stop move data while it is high
  // ------------------------------------------------------------------
  task automatic bus_bit(input logic b, output logic r);
    sda_m = b;
    wait_n(6);
    scl = 1'b1;
    wait_n(4);
    r = sda;
    wait_n(4);
    scl = 1'b0;
    wait_n(2);
  endtask
  task automatic bus_start();
    sda_m = 1'b1;
    wait_n(4);
    scl = 1'b1;
    wait_n(6);
    sda_m = 1'b0;
    wait_n(6);
    scl = 1'b0;
    wait_n(2);
  endtask
  task automatic bus_stop();
    sda_m = 1'b0;
    wait_n(4);
    scl = 1'b1;
    wait_n(6);
    sda_m = 1'b1;
    wait_n(6);
  endtask
  // msb first, then the ninth slot released by the master
  task automatic bus_byte(input logic [7:0] wb, output logic [7:0] rd,
                          output logic ack);
    for (int i = 7; i >= 0; i--) bus_bit(wb[i], rd[i]);
    bus_bit(1'b1, ack);
  endtask
  task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] rd;
    logic a;
    bus_start();
    bus_byte({`PSOV_DEV_ADDR, 1'b0}, rd, a);
    `CHK(a, 1'b0)
    bus_byte(ptr, rd, a);
    `CHK(a, 1'b0)
    bus_byte(d, rd, a);
    `CHK(a, 1'b0)
    bus_stop();
  endtask
  task automatic reg_rd(input logic [7:0] ptr, output logic [7:0] d);
    logic [7:0] rd;
    logic a;
    bus_start();
    bus_byte({`PSOV_DEV_ADDR, 1'b0}, rd, a);
    bus_byte(ptr, rd, a);
    bus_start();
    bus_byte({`PSOV_DEV_ADDR, 1'b1}, rd, a);
    `CHK(a, 1'b0)
    bus_byte(8'hFF, d, a);
    bus_stop();
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_vals();
    logic [7:0] d;
    `CHK(vr, exp_vr(3'h0, 3'h0))
    reg_rd(`PSOV_OVR_ADDR, d);
    `CHK(d, 8'h00)
  endtask
  // every override code against back-to-back commands
  task automatic t_modes();
    logic [7:0] d;
    for (int v = 0; v < 8; v++) begin
      reg_wr(`PSOV_OVR_ADDR, {5'h1F, v[2:0]});
      `CHK(override_bits, v[2:0])
      reg_rd(`PSOV_OVR_ADDR, d);
      `CHK(d, {5'h00, v[2:0]})
      cmd_u.send(1'b1, 3'h7);
      cmd_u.send(1'b1, 3'h0);
      `CHK(cmd_ack, 1'b1)
      `CHK(reported_state, 3'h7)
      `CHK(vr, exp_vr(v[2:0], 3'h7))
      cmd_u.send(1'b1, 3'h2);
      `CHK(vr, exp_vr(v[2:0], 3'h0))
      cmd_u.send(1'b0, 3'h0);
      `CHK(vr, exp_vr(v[2:0], 3'h2))
      cmd_u.send(1'b0, 3'h0);
      `CHK(cmd_ack, 1'b0)
    end
  endtask
  // a clearing write to the neighbour must not reach the override
  task automatic t_unmapped();
    logic [7:0] d, rd;
    logic a;
    // a foreign target address must get no acknowledge
    bus_start();
    bus_byte({`PSOV_DEV_ADDR ^ 7'h01, 1'b0}, rd, a);
    `CHK(a, 1'b1)
    bus_stop();
    reg_wr(8'h13, 8'h00);
    `CHK(override_bits, 3'h7)
    reg_rd(8'h13, d);
    `CHK(d, 8'h00)
  endtask
  // enable low: a command is not taken, report holds the last state
  task automatic t_freeze();
    ce = 1'b0;
    cmd_u.send(1'b1, 3'h3);
    cmd_u.send(1'b0, 3'h0);
    `CHK(cmd_ack, 1'b0)
    `CHK(reported_state, 3'h2)
    ce = 1'b1;
    cmd_u.send(1'b1, 3'h3);
    cmd_u.send(1'b0, 3'h0);
    `CHK(reported_state, 3'h3)
  endtask
  task automatic t_mid_reset();
    reg_wr(`PSOV_OVR_ADDR, 8'h05);
    cmd_u.send(1'b1, 3'h7);
    cmd_u.send(1'b0, 3'h0);
    srst = 1'b1;
    wait_n(1);
    srst = 1'b0;
    `CHK(override_bits, 3'h0)
    `CHK(reported_state, 3'h0)
    `CHK(vr, exp_vr(3'h0, 3'h0))
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    wait_n(4);
    srst = 1'b0;
    wait_n(4);
    t_reset_vals();
    t_modes();
    t_unmapped();
    t_freeze();
    t_mid_reset();
    stop_test();
  end
  // about 11k cycles expected; cut off well beyond that
  initial begin
    #320000;
    error_cnt++;
    stop_test();
  end
endmodule

bind psov_ctrl psov_ctrl_chk chk_u (.core_clk(core_clk), .srst(srst),
  .ce(ce), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .cmd(cmd), .cmd_ack(cmd_ack),
  .reported_state(reported_state), .vr(vr),
  .override_bits(override_bits));
